// file: rtl/asc_chan.v
// One async serial channel: transmitter, receiver, FIFO
`timescale 1ns/100ps
`default_nettype none
`include "asc_map.vh"
module asc_chan
(
   // Clock and reset
   input wire ref_clk_in,
   input wire resetn_in,
   input wire bit_tick_in,
   // Format
   input wire fmt_data_len_in,
   input wire fmt_parity_en_in,
   input wire fmt_stop_len_in,
   input wire fmt_parity_odd_in,
   // Holding register access
   input wire hold_wr_in,
   input wire [7:0] wdata_in,
   output reg [7:0] hold_out,
   output wire hold_empty_out,
   // Receive head
   input wire head_rd_in,
   output wire [7:0] head_out,
   output wire rx_full_flag_out,
   output reg overrun_flag_out,
   output reg frame_err_out,
   // Pins
   output reg serial_tx_out,
   input wire serial_rx_in
);
   // Transmitter
   localparam TX_IDLE = 2'b01;
   localparam TX_SHIFT = 2'b10;
   reg [1:0] tx_st_q;
   reg hold_full_q;
   reg [10:0] transmit_shift_reg;
   reg [3:0] tx_bits_q;
   reg [3:0] tx_tick_q;
   wire [3:0] frame_len;
   wire par_bit;
   assign hold_empty_out = ~hold_full_q;
   // Stop bits counted too, so a queued char never clips them
   assign frame_len = `ASC_FRAME_BASE + {3'h0, fmt_data_len_in} + {3'h0, fmt_parity_en_in}
      + {3'h0, fmt_stop_len_in};
   assign par_bit = (fmt_data_len_in ? ^hold_out : ^hold_out[6:0]) ^ fmt_parity_odd_in;
   always @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         tx_st_q <= TX_IDLE;
         hold_full_q <= 1'b0;
         hold_out <= `ASC_ZERO8;
         transmit_shift_reg <= 11'h7FF;
         tx_bits_q <= `ASC_ZERO4;
         tx_tick_q <= `ASC_ZERO4;
         serial_tx_out <= `ASC_IDLE;
      end
      else
      begin
         case (tx_st_q)
            TX_IDLE:
            begin
               serial_tx_out <= `ASC_IDLE;
               if (hold_full_q && bit_tick_in)
               begin
                  // Frame packed LSB first; unused tail bits stay high as stop level
                  if (fmt_data_len_in)
                     transmit_shift_reg <= {1'b1, fmt_parity_en_in ? par_bit : 1'b1,
                        hold_out, `ASC_START};
                  else
                     transmit_shift_reg <= {2'b11, fmt_parity_en_in ? par_bit : 1'b1,
                        hold_out[6:0], `ASC_START};
                  hold_full_q <= hold_wr_in;
                  tx_bits_q <= frame_len;
                  tx_tick_q <= `ASC_ZERO4;
                  tx_st_q <= TX_SHIFT;
               end
               else if (hold_wr_in)
                  hold_full_q <= 1'b1;
            end
            TX_SHIFT:
            begin
               if (hold_wr_in)
                  hold_full_q <= 1'b1;
               if (bit_tick_in)
               begin
                  if (tx_tick_q == `ASC_ZERO4)
                  begin
                     serial_tx_out <= transmit_shift_reg[0];
                     transmit_shift_reg <= {1'b1, transmit_shift_reg[10:1]};
                     tx_bits_q <= tx_bits_q - `ASC_ONE4;
                  end
                  else if (tx_tick_q == `ASC_OVS && tx_bits_q == `ASC_ZERO4)
                     tx_st_q <= TX_IDLE;
                  tx_tick_q <= tx_tick_q + `ASC_ONE4;
               end
            end
            default:
               tx_st_q <= TX_IDLE;
         endcase
         // Reads of the holding register never touch this path
         if (hold_wr_in)
            hold_out <= wdata_in;
      end
   end

   // Receiver
   localparam RX_IDLE = 3'b001;
   localparam RX_START = 3'b010;
   localparam RX_DATA = 3'b100;
   reg [2:0] rx_st_q;
   reg [3:0] rx_tick_q;
   reg [3:0] rx_bits_q;
   reg [9:0] receive_shift_reg;
   reg rsr_full_q;
   reg [7:0] rsr_char_q;
   reg rsr_ferr_q;
   reg ovr_pend_q;
   reg [2:0] ovr_age_q;
   wire fifo_ready;
   wire [2:0] fifo_cnt;
   wire char_done;
   wire push;
   wire pop;
   wire [3:0] rx_len;
   assign rx_len = 4'h7 + {3'h0, fmt_data_len_in} + {3'h0, fmt_parity_en_in};
   assign char_done = (rx_st_q == RX_DATA) && bit_tick_in && (rx_tick_q == `ASC_OVS_HALF)
      && (rx_bits_q == rx_len);
   assign push = rsr_full_q & fifo_ready;
   assign pop = head_rd_in & rx_full_flag_out;
   always @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         rx_st_q <= RX_IDLE;
         rx_tick_q <= `ASC_ZERO4;
         rx_bits_q <= `ASC_ZERO4;
         receive_shift_reg <= 10'h000;
         rsr_full_q <= 1'b0;
         rsr_char_q <= `ASC_ZERO8;
         rsr_ferr_q <= 1'b0;
         ovr_pend_q <= 1'b0;
         ovr_age_q <= 3'h0;
         overrun_flag_out <= 1'b0;
         frame_err_out <= 1'b0;
      end
      else
      begin
         case (rx_st_q)
            RX_IDLE:
               if (bit_tick_in && serial_rx_in == `ASC_START)
               begin
                  rx_tick_q <= `ASC_ZERO4;
                  rx_st_q <= RX_START;
               end
            RX_START:
               if (bit_tick_in)
               begin
                  rx_tick_q <= rx_tick_q + `ASC_ONE4;
                  if (rx_tick_q == `ASC_OVS_HALF)
                  begin
                     // Half a bit of offset puts every data sample mid-bit
                     rx_tick_q <= `ASC_OVS_MID;
                     rx_bits_q <= `ASC_ZERO4;
                     rx_st_q <= (serial_rx_in == `ASC_START) ? RX_DATA : RX_IDLE;
                  end
               end
            RX_DATA:
               if (bit_tick_in)
               begin
                  rx_tick_q <= rx_tick_q + `ASC_ONE4;
                  if (rx_tick_q == `ASC_OVS_HALF)
                  begin
                     // Keeps shifting even with the FIFO full
                     receive_shift_reg <= {serial_rx_in, receive_shift_reg[9:1]};
                     rx_bits_q <= rx_bits_q + `ASC_ONE4;
                     if (char_done)
                        rx_st_q <= RX_IDLE;
                  end
                  if (rx_tick_q == `ASC_OVS)
                     rx_tick_q <= `ASC_ZERO4;
               end
            default:
               rx_st_q <= RX_IDLE;
         endcase
         if (char_done)
         begin
            if (rsr_full_q && !push)
            begin
               ovr_pend_q <= 1'b1;
               ovr_age_q <= fifo_cnt - {2'h0, pop};
            end
            else
            begin
               rsr_full_q <= 1'b1;
               // Stop bit sampled last; low means framing error, char still kept
               rsr_ferr_q <= ~serial_rx_in;
               // Parity, when on, is the top bit and sits above the data
               if (fmt_data_len_in)
                  rsr_char_q <= fmt_parity_en_in ? receive_shift_reg[8:1]
                     : receive_shift_reg[9:2];
               else
                  rsr_char_q <= {1'b0, fmt_parity_en_in ? receive_shift_reg[8:2]
                     : receive_shift_reg[9:3]};
            end
         end
         else if (push)
         begin
            rsr_full_q <= 1'b0;
            frame_err_out <= rsr_ferr_q;
         end
         // Overrun shows once the last good char before it reaches the head
         if (ovr_pend_q && pop)
         begin
            if (ovr_age_q <= 3'h1)
            begin
               overrun_flag_out <= 1'b1;
               ovr_pend_q <= 1'b0;
            end
            else
               ovr_age_q <= ovr_age_q - 3'h1;
         end
         else if (ovr_pend_q && ovr_age_q == 3'h0)
         begin
            overrun_flag_out <= 1'b1;
            ovr_pend_q <= 1'b0;
         end
      end
   end

   asc_rx_fifo u_fifo
   (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .wr_valid_in(rsr_full_q),
      .wr_ready_out(fifo_ready),
      .wr_data_in(rsr_char_q),
      .rd_valid_out(rx_full_flag_out),
      .rd_ready_in(head_rd_in),
      .rd_data_out(head_out),
      .count_out(fifo_cnt)
   );
endmodule // asc_chan
`default_nettype wire

// file: rtl/asc_data_path.v
// Two-channel async serial data path with I/O-space data registers
`timescale 1ns/100ps
`default_nettype none
`include "asc_map.vh"
module asc_data_path
(
   // Clock and reset
   input wire ref_clk_in,
   input wire resetn_in,
   // Processor I/O port
   input wire [7:0] io_addr_in,
   input wire io_wr_in,
   input wire io_rd_in,
   input wire [7:0] io_wdata_in,
   output reg [7:0] io_rdata_out,
   output reg io_rvalid_out,
   // Bit rate and format, per channel
   input wire [1:0] bit_tick_in,
   input wire [1:0] fmt_data_len_in,
   input wire [1:0] fmt_parity_en_in,
   input wire [1:0] fmt_stop_len_in,
   input wire [1:0] fmt_parity_odd_in,
   // Status
   output wire [1:0] tx_hold_empty_out,
   output wire [1:0] rx_full_flag_out,
   output wire [1:0] overrun_flag_out,
   output wire [1:0] frame_err_out,
   // Serial pins
   output wire [1:0] serial_tx_out,
   input wire [1:0] serial_rx_in
);
   wire [7:0] hold_q [0:1];
   wire [7:0] head_q [0:1];
   wire [1:0] hold_wr;
   wire [1:0] head_rd;
   // Only the four data registers decode; shift registers have none
   assign hold_wr[0] = io_wr_in && io_addr_in == `ASC_ADDR_TX_HOLD0;
   assign hold_wr[1] = io_wr_in && io_addr_in == `ASC_ADDR_TX_HOLD1;
   assign head_rd[0] = io_rd_in && io_addr_in == `ASC_ADDR_RX_HEAD0;
   assign head_rd[1] = io_rd_in && io_addr_in == `ASC_ADDR_RX_HEAD1;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_chan
         asc_chan u_chan
         (
            .ref_clk_in(ref_clk_in),
            .resetn_in(resetn_in),
            .bit_tick_in(bit_tick_in[g]),
            .fmt_data_len_in(fmt_data_len_in[g]),
            .fmt_parity_en_in(fmt_parity_en_in[g]),
            .fmt_stop_len_in(fmt_stop_len_in[g]),
            .fmt_parity_odd_in(fmt_parity_odd_in[g]),
            .hold_wr_in(hold_wr[g]),
            .wdata_in(io_wdata_in),
            .hold_out(hold_q[g]),
            .hold_empty_out(tx_hold_empty_out[g]),
            .head_rd_in(head_rd[g]),
            .head_out(head_q[g]),
            .rx_full_flag_out(rx_full_flag_out[g]),
            .overrun_flag_out(overrun_flag_out[g]),
            .frame_err_out(frame_err_out[g]),
            .serial_tx_out(serial_tx_out[g]),
            .serial_rx_in(serial_rx_in[g])
         );
      end
   endgenerate

   // Read data registered one cycle after the strobe; unmapped reads give zero
   always @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         io_rdata_out <= `ASC_ZERO8;
         io_rvalid_out <= 1'b0;
      end
      else
      begin
         io_rvalid_out <= io_rd_in;
         case (io_addr_in)
            `ASC_ADDR_TX_HOLD0: io_rdata_out <= hold_q[0];
            `ASC_ADDR_TX_HOLD1: io_rdata_out <= hold_q[1];
            `ASC_ADDR_RX_HEAD0: io_rdata_out <= head_q[0];
            `ASC_ADDR_RX_HEAD1: io_rdata_out <= head_q[1];
            default: io_rdata_out <= `ASC_ZERO8;
         endcase
      end
   end
endmodule // asc_data_path
`default_nettype wire

// file: rtl/asc_map.vh
// Register map and constants for the async serial data path
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
`define ASC_ADDR_TX_HOLD0 8'h06
`define ASC_ADDR_TX_HOLD1 8'h07
`define ASC_ADDR_RX_HEAD0 8'h08
`define ASC_ADDR_RX_HEAD1 8'h09
`define ASC_FIFO_DEPTH 3'h4
`define ASC_FIFO_AW 2
`define ASC_OVS 4'hF
`define ASC_OVS_HALF 4'h7
`define ASC_OVS_MID 4'h8
// Start, 7 data and 1 stop; options add to it
`define ASC_FRAME_BASE 4'h9
`define ASC_IDLE 1'b1
`define ASC_START 1'b0
`define ASC_ZERO8 8'h00
`define ASC_ZERO4 4'h0
`define ASC_ONE4 4'h1
`endif

// file: rtl/asc_rx_fifo.v
// Four-entry receive character FIFO with registered head output
`timescale 1ns/100ps
`default_nettype none
`include "asc_map.vh"
module asc_rx_fifo
(
   // Clock and reset
   input wire ref_clk_in,
   input wire resetn_in,
   // Write side
   input wire wr_valid_in,
   output wire wr_ready_out,
   input wire [7:0] wr_data_in,
   // Read side
   output wire rd_valid_out,
   input wire rd_ready_in,
   output reg [7:0] rd_data_out,
   output wire [2:0] count_out
);
   reg [7:0] mem_q [0:3];
   reg [1:0] wp_q;
   reg [1:0] rp_q;
   reg [2:0] cnt_q;
   wire push;
   wire pop;
   wire [1:0] rp_n;
   assign wr_ready_out = (cnt_q != `ASC_FIFO_DEPTH);
   assign rd_valid_out = (cnt_q != 3'h0);
   assign push = wr_valid_in & wr_ready_out;
   assign pop = rd_valid_out & rd_ready_in;
   assign count_out = cnt_q;
   assign rp_n = pop ? rp_q + 2'h1 : rp_q;
   always @(posedge ref_clk_in)
   begin
      if (push)
         mem_q[wp_q] <= wr_data_in;
      if (!resetn_in)
      begin
         wp_q <= 2'h0;
         rp_q <= 2'h0;
         cnt_q <= 3'h0;
         rd_data_out <= `ASC_ZERO8;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 2'h1;
         rp_q <= rp_n;
         cnt_q <= cnt_q + {2'h0, push} - {2'h0, pop};
         // Head register bypasses memory when writing into an empty slot at head
         if (push && (wp_q == rp_n) && (cnt_q == {2'h0, pop}))
            rd_data_out <= wr_data_in;
         else
            rd_data_out <= mem_q[rp_n];
      end
   end
endmodule // asc_rx_fifo
`default_nettype wire

// file: testbench/asc_checker.sv
// Port-level assertions for the async serial data path
`timescale 1ns/100ps
`default_nettype none
module asc_checker
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Processor side
   input wire logic [7:0] io_addr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic io_rvalid_out,
   // Status and pins
   input wire logic [1:0] rx_full_flag_out,
   input wire logic [1:0] overrun_flag_out,
   input wire logic [1:0] serial_tx_out
);
   logic pop_q;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   // A start bit spans 16 ticks, so at least 16 clocks; each sequence checks only 8 low clocks
   sequence start0_s;
      !serial_tx_out[0] [*8];
   endsequence
   sequence start1_s;
      !serial_tx_out[1] [*8];
   endsequence
   always @(posedge ref_clk_in)
   begin
      pop_q <= io_rd_in && io_addr_in == 8'h08;
   end
   a_rvalid_after_rd: assert property (io_rd_in |=> io_rvalid_out)
      else $error("read answer missing");
   a_no_spurious_rvalid: assert property (!io_rd_in |=> !io_rvalid_out)
      else $error("read answer without read");
   a_unmapped_read_zero: assert property (io_rd_in && (io_addr_in < 8'h06 ||
      io_addr_in > 8'h09) |=> io_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_start_bit_ch0: assert property ($fell(serial_tx_out[0]) |-> start0_s)
      else $error("channel 0 start bit too short");
   a_start_bit_ch1: assert property ($fell(serial_tx_out[1]) |-> start1_s)
      else $error("channel 1 start bit too short");
   a_overrun_sticky: assert property (overrun_flag_out[0] |=> overrun_flag_out[0])
      else $error("overrun flag dropped");
   a_overrun_at_head: assert property ($rose(overrun_flag_out[0]) |-> rx_full_flag_out[0])
      else $error("overrun raised with empty fifo");
   a_full_falls_read: assert property ($fell(rx_full_flag_out[0]) |-> pop_q || $past(pop_q))
      else $error("full flag fell without a read");
endmodule // asc_checker
`default_nettype wire

// file: testbench/asc_data_path_bench.sv
// Self-checking bench for the two-channel async serial data path
`timescale 1ns/100ps
`default_nettype none
module asc_data_path_bench;
   typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d;} asc_row_t;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] io_addr_in = 8'h00;
   logic io_wr_in = 1'b0;
   logic io_rd_in = 1'b0;
   logic [7:0] io_wdata_in = 8'h00;
   logic [1:0] bit_tick_in = 2'h0;
   logic [1:0] fmt_data_len_in = 2'h3;
   logic [1:0] fmt_parity_en_in = 2'h0;
   logic [1:0] fmt_stop_len_in = 2'h0;
   logic [1:0] fmt_parity_odd_in = 2'h0;
   wire [7:0] io_rdata_out;
   wire io_rvalid_out;
   wire [1:0] hold_empty, full, ovr, ferr, tx, rx;
   int num_errors = 0;
   int cmp_count = 0;
   logic [7:0] b;
   asc_row_t rows[9] = '{'{1'b1, 8'h06, 8'hA5}, '{1'b0, 8'h06, 8'hA5},
      '{1'b1, 8'h07, 8'h3C}, '{1'b0, 8'h07, 8'h3C}, '{1'b0, 8'h0A, 8'h00},
      '{1'b1, 8'h08, 8'hFF}, '{1'b0, 8'h05, 8'h00}, '{1'b1, 8'h06, 8'h5A},
      '{1'b0, 8'h06, 8'h5A}};
   asc_data_path i_asc_data_path (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
      .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
      .io_rvalid_out(io_rvalid_out), .bit_tick_in(bit_tick_in),
      .fmt_data_len_in(fmt_data_len_in), .fmt_parity_en_in(fmt_parity_en_in),
      .fmt_stop_len_in(fmt_stop_len_in), .fmt_parity_odd_in(fmt_parity_odd_in),
      .tx_hold_empty_out(hold_empty), .rx_full_flag_out(full),
      .overrun_flag_out(ovr), .frame_err_out(ferr), .serial_tx_out(tx),
      .serial_rx_in(rx));
   asc_remote i_asc_remote_0 (.ref_clk_in(ref_clk_in), .bit_tick_in(bit_tick_in[0]),
      .serial_tx_in(tx[0]), .serial_rx_out(rx[0]));
   asc_remote i_asc_remote_1 (.ref_clk_in(ref_clk_in), .bit_tick_in(bit_tick_in[1]),
      .serial_tx_in(tx[1]), .serial_rx_out(rx[1]));
   initial
   begin
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   // Tick every other clock keeps frames short
   always @(posedge ref_clk_in) bit_tick_in <= #1 ~bit_tick_in;
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Each access ends with an idle cycle so strobes never toggle twice at once
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      io_addr_in = a;
      io_wdata_in = d;
      io_wr_in = 1'b1;
      @(posedge ref_clk_in) #1;
      io_wr_in = 1'b0;
      @(posedge ref_clk_in) #1;
   endtask
   task automatic io_rd(input logic [7:0] a, input logic [7:0] exp);
      io_addr_in = a;
      io_rd_in = 1'b1;
      @(posedge ref_clk_in) #1;
      io_rd_in = 1'b0;
      check8({7'h00, io_rvalid_out}, 8'h01);
      check8(io_rdata_out, exp);
      @(posedge ref_clk_in) #1;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wrap_up;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      idle(30000);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
   initial
   begin
      idle(6);
      check8({tx, hold_empty, full, ovr}, 8'hF0);
      resetn_in = 1'b1;
      $display("reset test done");
      foreach (rows[i])
         if (rows[i].wr)
            io_wr(rows[i].a, rows[i].d);
         else
            io_rd(rows[i].a, rows[i].d);
      check8({6'h00, hold_empty}, 8'h02);
      for (int n = 0; n < 3000 && i_asc_remote_0.got_q.size() < 2; n++) idle(1);
      check8(i_asc_remote_0.got_q[0], 8'hA5);
      check8(i_asc_remote_0.got_q[1], 8'h5A);
      check8(i_asc_remote_1.got_q[0], 8'h3C);
      idle(40);
      check8({6'h00, tx}, 8'h03);
      check8({6'h00, hold_empty}, 8'h03);
      $display("table and transmit tests done");
      i_asc_remote_0.send(8'h11, 8);
      idle(40);
      check8({6'h00, full}, 8'h01);
      for (b = 8'h12; b != 8'h17; b++) i_asc_remote_0.send(b, 8);
      idle(40);
      check8({6'h00, ovr}, 8'h00);
      for (b = 8'h11; b != 8'h14; b++) io_rd(8'h08, b);
      check8({6'h00, ovr}, 8'h00);
      io_rd(8'h08, 8'h14);
      idle(4);
      check8({6'h00, ovr}, 8'h01);
      io_rd(8'h08, 8'h15);
      idle(4);
      check8({6'h00, full}, 8'h00);
      $display("overrun test done");
      fmt_data_len_in = 2'h1;
      i_asc_remote_1.send(8'hD5, 7);
      idle(40);
      io_rd(8'h09, 8'h55);
      $display("seven bit test done");
      // Eighth bit low lands where the 7-bit frame expects its stop
      i_asc_remote_1.send(8'h41, 8);
      idle(40);
      check8({6'h00, ferr}, 8'h02);
      io_rd(8'h09, 8'h41);
      $display("framing test done");
      fmt_parity_en_in = 2'h2;
      fmt_parity_odd_in = 2'h2;
      fmt_stop_len_in = 2'h2;
      i_asc_remote_1.send(8'hD5, 8);
      idle(40);
      io_rd(8'h09, 8'h55);
      check8({6'h00, ferr}, 8'h00);
      io_wr(8'h07, 8'h55);
      for (int n = 0; n < 3000 && i_asc_remote_1.got_q.size() < 2; n++) idle(1);
      check8(i_asc_remote_1.got_q[1], 8'hD5);
      $display("parity test done");
      wrap_up();
   end
endmodule // asc_data_path_bench
bind asc_data_path asc_checker i_asc_checker (.ref_clk_in(ref_clk_in),
   .resetn_in(resetn_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in),
   .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
   .rx_full_flag_out(rx_full_flag_out), .overrun_flag_out(overrun_flag_out),
   .serial_tx_out(serial_tx_out));
`default_nettype wire

// file: testbench/asc_remote.sv
// Remote serial party: sends frames on rx, decodes 8-bit frames from tx
`timescale 1ns/100ps
`default_nettype none
module asc_remote
(
   // Clock and tick
   input wire logic ref_clk_in,
   input wire logic bit_tick_in,
   // Pins
   input wire logic serial_tx_in,
   output logic serial_rx_out
);
   logic [7:0] got_q[$];
   logic [7:0] sh;
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge ref_clk_in);
         while (!bit_tick_in) @(posedge ref_clk_in);
      end
      #1;
   endtask
   task automatic send(input logic [7:0] b, input int nb);
      serial_rx_out = 1'b0;
      ticks(16);
      for (int i = 0; i < nb; i++)
      begin
         serial_rx_out = b[i];
         ticks(16);
      end
      serial_rx_out = 1'b1;
      ticks(16);
   endtask
   initial
   begin
      serial_rx_out = 1'b1;
      forever
      begin
         @(negedge serial_tx_in);
         ticks(8);
         for (int k = 0; k < 8; k++)
         begin
            ticks(16);
            sh[k] = serial_tx_in;
         end
         ticks(16);
         got_q.push_back(sh);
      end
   end
endmodule // asc_remote
`default_nettype wire
